// >>> logic/rsr_cfg.svh
// Constants for the remote speed and ramp-time selection block
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define RSR_CLK_HZ 10000000
`define RSR_STORE_PERIOD_S 60
`define RSR_TIME_UNIT0_MS 100
`define RSR_TIME_UNIT1_MS 10
`define RSR_UNIT0_CYC (`RSR_CLK_HZ / 1000 * `RSR_TIME_UNIT0_MS)
`define RSR_UNIT1_CYC (`RSR_CLK_HZ / 1000 * `RSR_TIME_UNIT1_MS)

// ----------------------------------------
// Value limits (frequencies in 0.1 Hz, times in increments)
// ----------------------------------------
`define RSR_TIME_MAX 16'h8ca0
`define RSR_DISABLE_CODE 16'h270f
`define RSR_FREQ_MAX 16'h0fa0
`define RSR_REF_MIN 16'h000a
`define RSR_FREQ_SAT 16'hffff

// ----------------------------------------
// Remote mode codes and control fields
// ----------------------------------------
`define RSR_MODE_OFF 2'h0
`define RSR_MODE_STORE 2'h1
`define RSR_CTRL_MODE_LSB 0
`define RSR_CTRL_MODE_MSB 1
`define RSR_CTRL_INC_BIT 2

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSR_OFF_CTRL 8'h00
`define RSR_OFF_MAXF 8'h04
`define RSR_OFF_REFF 8'h08
`define RSR_OFF_ACC1 8'h0c
`define RSR_OFF_DEC1 8'h10
`define RSR_OFF_ACC2 8'h14
`define RSR_OFF_DEC2 8'h18
`define RSR_OFF_SWF 8'h1c
`define RSR_OFF_MAIN 8'h20
`define RSR_OFF_OUTF 8'h24
`define RSR_OFF_REMF 8'h28
`define RSR_OFF_STAT 8'h2c
`define RSR_OFF_NVF 8'h30

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSR_RST_MAXF 16'h04b0
`define RSR_RST_REFF 16'h01f4
`define RSR_RST_TIME 16'h0032
`define RSR_RST_DEC2 16'h270f
`define RSR_RST_SWF 16'h270f
`define RSR_RST_MAIN 16'h0000

`endif

// >>> logic/rsr_pkg.sv
// Types shared by the remote speed and ramp-time selection block
package rsr_pkg;

   // ----------------------------------------
   // Contact inputs after synchronisation
   // ----------------------------------------
   typedef struct packed {
      logic remote_up_input;
      logic remote_down_input;
      logic remote_clear_input;
      logic second_function_select;
      logic forward_run_cmd;
      logic reverse_run_cmd;
      logic jog_active;
      logic pid_active;
   } rsr_pins_t;

   // ----------------------------------------
   // Software configuration
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] remote_mode_select;
      logic ramp_time_increment_sel;
      logic [15:0] max_frequency;
      logic [15:0] ramp_reference_freq;
      logic [15:0] first_accel_time;
      logic [15:0] first_decel_time;
      logic [15:0] second_accel_time;
      logic [15:0] second_decel_time;
      logic [15:0] ramp_switch_freq;
      logic [15:0] main_freq;
   } rsr_cfg_t;

   // ----------------------------------------
   // Setpoint storage states
   // ----------------------------------------
   typedef enum logic [1:0] {
      RSR_ST_IDLE = 2'b01,
      RSR_ST_TIMING = 2'b10
   } rsr_store_st_t;

endpackage

// >>> logic/rsr_ramp_step.sv
// Linear ramp: steps a frequency toward a target at ref per ramp span
module rsr_ramp_step (
   input wire logic i_clk_sys, // System clock
   input wire logic i_rst_n, // Synchronised reset, active low
   input wire logic [15:0] i_target, // Frequency to reach
   input wire logic [15:0] i_ref, // Reference frequency of a full ramp
   input wire logic [35:0] i_acc_cyc, // Cycles to rise by i_ref
   input wire logic [35:0] i_dec_cyc, // Cycles to fall by i_ref
   input wire logic i_load, // Force o_freq to i_load_val
   input wire logic [15:0] i_load_val, // Value forced by i_load
   output logic [15:0] o_freq // Present frequency
);

   logic [15:0] freq;
   logic [15:0] next_freq;
   logic [35:0] acc;
   logic [35:0] next_acc;
   logic [35:0] span;
   logic [35:0] sum;

   // ----------------------------------------
   // Fractional accumulator, one step of 0.1 Hz at most per cycle
   // ----------------------------------------
   always_comb begin
      next_freq = freq;
      next_acc = acc;
      span = (i_target > freq) ? i_acc_cyc : i_dec_cyc;
      sum = acc + {20'h0, i_ref};
      if (i_load) begin
         next_freq = i_load_val;
         next_acc = 36'h0;
      end else if (freq == i_target) begin
         // Idle accumulator so the next ramp starts clean
         next_acc = 36'h0;
      end else if (sum >= span) begin
         next_acc = sum - span;
         next_freq = (i_target > freq) ? freq + 16'h1 : freq - 16'h1;
      end else begin
         next_acc = sum;
      end
   end

   // Registers
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freq <= 16'h0;
         acc <= 36'h0;
      end else begin
         freq <= next_freq;
         acc <= next_acc;
      end
   end

   assign o_freq = freq;

endmodule

// >>> logic/rsr_top.sv
// Remote setpoint, ramp-time selection and output ramp with APB registers
//
// Our own choices: the APB register port and the register addresses.
`include "rsr_cfg.svh"

module rsr_top #(
   parameter int unsigned STORE_CYC = `RSR_STORE_PERIOD_S * `RSR_CLK_HZ
) (
   input wire logic i_clk_sys, // System clock, 10 MHz
   input wire logic i_arst_n, // Asynchronous reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error on unmapped address
   input wire logic i_remote_up_input, // Raise contact
   input wire logic i_remote_down_input, // Lower contact
   input wire logic i_remote_clear_input, // Clear contact
   input wire logic i_second_function_select, // Second function contact
   input wire logic i_forward_run_cmd, // Forward run contact
   input wire logic i_reverse_run_cmd, // Reverse run contact
   input wire logic i_jog_active, // Jog operation in progress
   input wire logic i_pid_active, // PID control in progress
   input wire logic [15:0] i_nv_data, // Setpoint held in storage
   output logic o_nv_wr, // Storage write strobe
   output logic [15:0] o_nv_data, // Setpoint to store
   output logic [15:0] o_out_freq, // Output frequency, 0.1 Hz
   output logic [15:0] o_set_freq // Set frequency, 0.1 Hz
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      max16 = (a > b) ? a : b;
   endfunction

   function automatic logic [15:0] lim16(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      lim16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // Time setting to cycles; a zero setting still takes one increment
   function automatic logic [35:0] t2cyc(input logic [15:0] t, input logic inc);
      logic [35:0] unit;
      unit = inc ? 36'(`RSR_UNIT1_CYC) : 36'(`RSR_UNIT0_CYC);
      t2cyc = ((t == 16'h0) ? 36'h1 : {20'h0, t}) * unit;
   endfunction

   // ----------------------------------------
   // Reset release and contact synchronisers
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;
   rsr_pkg::rsr_pins_t pins_raw;
   rsr_pkg::rsr_pins_t pins_meta;
   rsr_pkg::rsr_pins_t pins;

   // Reset enters asynchronously, leaves synchronously two edges later
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign pins_raw = '{i_remote_up_input, i_remote_down_input, i_remote_clear_input,
                       i_second_function_select, i_forward_run_cmd, i_reverse_run_cmd,
                       i_jog_active, i_pid_active};

   // Contacts are asynchronous; only the second stage is read
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta <= '0;
         pins <= '0;
      end else begin
         pins_meta <= pins_raw;
         pins <= pins_meta;
      end
   end

   // ----------------------------------------
   // APB register file
   // ----------------------------------------
   rsr_pkg::rsr_cfg_t cfg;
   rsr_pkg::rsr_cfg_t next_cfg;
   logic [31:0] rd_data;
   logic [31:0] next_rd_data;
   logic addr_ok;
   logic wr_en;
   logic [15:0] wval;
   logic [15:0] tval;
   logic [15:0] remote_freq;
   logic [15:0] out_freq;
   logic [15:0] set_freq;
   logic [15:0] stored;
   logic store_busy;
   logic second_act;
   logic remote_en;
   logic run;

   always_comb begin
      unique case (i_paddr)
         `RSR_OFF_CTRL, `RSR_OFF_MAXF, `RSR_OFF_REFF, `RSR_OFF_ACC1, `RSR_OFF_DEC1,
         `RSR_OFF_ACC2, `RSR_OFF_DEC2, `RSR_OFF_SWF, `RSR_OFF_MAIN, `RSR_OFF_OUTF,
         `RSR_OFF_REMF, `RSR_OFF_STAT, `RSR_OFF_NVF: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Zero wait states: read data is captured in the setup cycle
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~addr_ok;
   assign o_prdata = rd_data;
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign wval = i_pwdata[15:0];
   assign tval = (wval > `RSR_TIME_MAX) ? `RSR_TIME_MAX : wval;

   // Write decode; out-of-range values saturate rather than being refused
   always_comb begin
      next_cfg = cfg;
      if (wr_en) begin
         unique case (i_paddr)
            `RSR_OFF_CTRL: begin
               next_cfg.remote_mode_select = i_pwdata[`RSR_CTRL_MODE_MSB:`RSR_CTRL_MODE_LSB];
               next_cfg.ramp_time_increment_sel = i_pwdata[`RSR_CTRL_INC_BIT];
            end
            `RSR_OFF_MAXF: next_cfg.max_frequency = lim16(wval, 16'h0, `RSR_FREQ_MAX);
            `RSR_OFF_REFF: next_cfg.ramp_reference_freq =
                              lim16(wval, `RSR_REF_MIN, `RSR_FREQ_MAX);
            `RSR_OFF_ACC1: next_cfg.first_accel_time = tval;
            `RSR_OFF_DEC1: next_cfg.first_decel_time = tval;
            `RSR_OFF_ACC2: next_cfg.second_accel_time = tval;
            `RSR_OFF_DEC2: next_cfg.second_decel_time =
                              (wval == `RSR_DISABLE_CODE) ? wval : tval;
            `RSR_OFF_SWF: next_cfg.ramp_switch_freq = (wval == `RSR_DISABLE_CODE) ?
                              wval : lim16(wval, 16'h0, `RSR_FREQ_MAX);
            `RSR_OFF_MAIN: next_cfg.main_freq = lim16(wval, 16'h0, `RSR_FREQ_MAX);
            default: next_cfg = cfg;
         endcase
      end
   end

   // Read mux
   always_comb begin
      next_rd_data = rd_data;
      if (i_psel & ~i_penable) begin
         unique case (i_paddr)
            `RSR_OFF_CTRL: next_rd_data = {29'h0, cfg.ramp_time_increment_sel,
                                           cfg.remote_mode_select};
            `RSR_OFF_MAXF: next_rd_data = {16'h0, cfg.max_frequency};
            `RSR_OFF_REFF: next_rd_data = {16'h0, cfg.ramp_reference_freq};
            `RSR_OFF_ACC1: next_rd_data = {16'h0, cfg.first_accel_time};
            `RSR_OFF_DEC1: next_rd_data = {16'h0, cfg.first_decel_time};
            `RSR_OFF_ACC2: next_rd_data = {16'h0, cfg.second_accel_time};
            `RSR_OFF_DEC2: next_rd_data = {16'h0, cfg.second_decel_time};
            `RSR_OFF_SWF: next_rd_data = {16'h0, cfg.ramp_switch_freq};
            `RSR_OFF_MAIN: next_rd_data = {16'h0, cfg.main_freq};
            `RSR_OFF_OUTF: next_rd_data = {16'h0, out_freq};
            `RSR_OFF_REMF: next_rd_data = {16'h0, remote_freq};
            `RSR_OFF_STAT: next_rd_data = {28'h0, store_busy, second_act, remote_en, run};
            `RSR_OFF_NVF: next_rd_data = {16'h0, stored};
            default: next_rd_data = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '{`RSR_MODE_OFF, 1'b0, `RSR_RST_MAXF, `RSR_RST_REFF, `RSR_RST_TIME,
                  `RSR_RST_TIME, `RSR_RST_TIME, `RSR_RST_DEC2, `RSR_RST_SWF, `RSR_RST_MAIN};
         rd_data <= 32'h0;
      end else begin
         cfg <= next_cfg;
         rd_data <= next_rd_data;
      end
   end

   // ----------------------------------------
   // Remote contact decode
   // ----------------------------------------
   logic up_act;
   logic dn_act;
   logic clr_act;
   logic booted;
   logic [15:0] rem_target;
   logic [16:0] sum_freq;
   logic [16:0] cap_freq;

   // Jog or PID suspends the raise, lower and clear contacts; storage keeps running
   assign remote_en = (cfg.remote_mode_select != `RSR_MODE_OFF) & ~pins.jog_active &
                      ~pins.pid_active;
   assign up_act = remote_en & pins.remote_up_input & ~pins.remote_down_input;
   assign dn_act = remote_en & pins.remote_down_input & ~pins.remote_up_input;
   assign clr_act = remote_en & pins.remote_clear_input;
   assign run = pins.forward_run_cmd | pins.reverse_run_cmd;

   // Raise toward maximum, lower toward zero, else hold inside range
   always_comb begin
      if (up_act) begin
         rem_target = cfg.max_frequency;
      end else if (dn_act) begin
         rem_target = 16'h0;
      end else begin
         rem_target = (remote_freq > cfg.max_frequency) ? cfg.max_frequency : remote_freq;
      end
   end

   // Set frequency: main plus remote offset, capped at main plus maximum; main alone in mode 0
   always_comb begin
      sum_freq = {1'b0, cfg.main_freq} + {1'b0, remote_freq};
      cap_freq = {1'b0, cfg.main_freq} + {1'b0, cfg.max_frequency};
      if (sum_freq > cap_freq) begin
         sum_freq = cap_freq;
      end
      if (cfg.remote_mode_select == `RSR_MODE_OFF) begin
         set_freq = cfg.main_freq;
      end else if (sum_freq[16]) begin
         set_freq = `RSR_FREQ_SAT;
      end else begin
         set_freq = sum_freq[15:0];
      end
   end

   // ----------------------------------------
   // Ramp-time selection
   // ----------------------------------------
   logic [15:0] dec2_eff;
   logic [15:0] acc_sel;
   logic [15:0] dec_sel;
   logic [35:0] acc_cyc;
   logic [35:0] dec_cyc;
   logic [15:0] ref_eff;

   assign dec2_eff = (cfg.second_decel_time == `RSR_DISABLE_CODE) ?
                     cfg.second_accel_time : cfg.second_decel_time;
   assign second_act = (cfg.ramp_switch_freq != `RSR_DISABLE_CODE) &
                       (out_freq >= cfg.ramp_switch_freq);
   assign ref_eff = lim16(cfg.ramp_reference_freq, `RSR_REF_MIN, `RSR_FREQ_MAX);

   // Second function wins over everything except in jog, then remote, then threshold
   always_comb begin
      if (pins.second_function_select & ~pins.jog_active) begin
         acc_sel = cfg.second_accel_time;
         dec_sel = dec2_eff;
      end else if (up_act | dn_act) begin
         acc_sel = max16(cfg.first_accel_time, cfg.second_accel_time);
         dec_sel = max16(cfg.first_decel_time, dec2_eff);
      end else if (second_act) begin
         acc_sel = cfg.second_accel_time;
         dec_sel = dec2_eff;
      end else begin
         acc_sel = cfg.first_accel_time;
         dec_sel = cfg.first_decel_time;
      end
      acc_cyc = t2cyc(acc_sel, cfg.ramp_time_increment_sel);
      dec_cyc = t2cyc(dec_sel, cfg.ramp_time_increment_sel);
   end

   // ----------------------------------------
   // Remote setpoint and output ramps
   // ----------------------------------------
   // Boot load restores the stored setpoint; a clear forces zero
   rsr_ramp_step u_remote_ramp (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_target(rem_target),
      .i_ref(ref_eff),
      .i_acc_cyc(acc_cyc),
      .i_dec_cyc(dec_cyc),
      .i_load(~booted | clr_act),
      .i_load_val(booted ? 16'h0 : lim16(i_nv_data, 16'h0, `RSR_FREQ_MAX)),
      .o_freq(remote_freq)
   );

   // Output follows the set frequency while running, else ramps to stop
   rsr_ramp_step u_out_ramp (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_target(run ? set_freq : 16'h0),
      .i_ref(ref_eff),
      .i_acc_cyc(acc_cyc),
      .i_dec_cyc(dec_cyc),
      .i_load(1'b0),
      .i_load_val(16'h0),
      .o_freq(out_freq)
   );

   // ----------------------------------------
   // Setpoint storage
   // ----------------------------------------
   rsr_pkg::rsr_store_st_t st;
   rsr_pkg::rsr_store_st_t next_st;
   logic [31:0] timer;
   logic [31:0] next_timer;
   logic [1:0] ud_prev;
   logic run_prev;
   logic next_wr;
   logic [15:0] next_stored;
   logic store_mode;
   logic ud_change;

   assign store_mode = (cfg.remote_mode_select == `RSR_MODE_STORE);
   assign ud_change = ({pins.remote_up_input, pins.remote_down_input} != ud_prev);
   assign store_busy = (st == rsr_pkg::RSR_ST_TIMING);

   // Periodic save restarts on each up/down change; a clear is saved only later
   always_comb begin
      next_st = st;
      next_timer = timer;
      next_wr = 1'b0;
      next_stored = stored;
      unique case (st)
         rsr_pkg::RSR_ST_IDLE: begin
            next_timer = 32'h0;
            if (store_mode & ud_change) begin
               next_st = rsr_pkg::RSR_ST_TIMING;
            end
         end
         rsr_pkg::RSR_ST_TIMING: begin
            next_timer = timer + 32'h1;
            if (!store_mode) begin
               next_st = rsr_pkg::RSR_ST_IDLE;
            end else if (ud_change) begin
               next_timer = 32'h0;
            end else if (timer == STORE_CYC - 32'h1) begin
               next_timer = 32'h0;
               next_wr = (remote_freq != stored);
            end
         end
      endcase
      // Start signal turning off also saves the setpoint
      if (store_mode & run_prev & ~run & (remote_freq != stored)) begin
         next_wr = 1'b1;
      end
      if (next_wr) begin
         next_stored = remote_freq;
      end
      if (!booted) begin
         next_stored = lim16(i_nv_data, 16'h0, `RSR_FREQ_MAX);
         next_wr = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= rsr_pkg::RSR_ST_IDLE;
         timer <= 32'h0;
         o_nv_wr <= 1'b0;
         stored <= 16'h0;
         ud_prev <= 2'h0;
         run_prev <= 1'b0;
         booted <= 1'b0;
      end else begin
         st <= next_st;
         timer <= next_timer;
         o_nv_wr <= next_wr;
         stored <= next_stored;
         ud_prev <= {pins.remote_up_input, pins.remote_down_input};
         run_prev <= run;
         booted <= 1'b1;
      end
   end

   // Registered outputs
   assign o_nv_data = stored;
   assign o_out_freq = out_freq;

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_set_freq <= 16'h0;
      end else begin
         o_set_freq <= set_freq;
      end
   end

endmodule

// >>> test/rsr_top_checker.sv
// Port assertions for the remote speed and ramp block
module rsr_top_checker (
   input wire logic i_clk_sys, // Clock
   input wire logic i_arst_n, // Reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic [7:0] i_paddr, // APB address
   input wire logic o_pslverr, // APB error
   input wire logic i_forward_run_cmd, // Forward run
   input wire logic i_reverse_run_cmd, // Reverse run
   input wire logic i_jog_active, // Jog
   input wire logic o_nv_wr, // Store strobe
   input wire logic [15:0] o_nv_data, // Stored image
   input wire logic [15:0] o_out_freq, // Output frequency
   input wire logic [15:0] o_set_freq // Set frequency
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // Checks
   // ------
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // Error only for words past the map
   slverr_unmapped_a: assert property (i_psel && i_penable && i_paddr > 8'h30 |-> o_pslverr)
      else $error("no error on unmapped word");
   slverr_mapped_a: assert property (i_psel && i_penable && i_paddr <= 8'h30 &&
      i_paddr[1:0] == 2'b00 |-> !o_pslverr) else $error("error on mapped word");
   slverr_phase_a: assert property (o_pslverr |-> i_psel && i_penable)
      else $error("error outside access");
   // Store strobe is single and carries a new value
   nv_pulse_a: assert property (o_nv_wr |=> !o_nv_wr) else $error("long strobe");
   nv_new_a: assert property (o_nv_wr |-> o_nv_data != $past(o_nv_data))
      else $error("store of same value");
   // Output moves one step a cycle at most
   out_step_a: assert property ($changed(o_out_freq) |->
      o_out_freq - $past(o_out_freq) == 16'h0001 || $past(o_out_freq) - o_out_freq == 16'h0001)
      else $error("output jumped");
   // Windows of eight cycles cover the input synchronisers
   run_off_a: assert property ((!i_forward_run_cmd && !i_reverse_run_cmd)[*8] |=>
      o_out_freq <= $past(o_out_freq)) else $error("output rose without run");
   jog_hold_a: assert property ((i_jog_active && !i_psel)[*8] |-> $stable(o_set_freq))
      else $error("set frequency moved in jog");
endmodule

// >>> test/rsr_far_model.sv
// Far side: contact wiring and the setpoint storage
module rsr_far_model (
   input wire logic i_clk_sys, // Clock
   input wire rsr_pkg::rsr_pins_t i_want, // Contact states asked for
   input wire logic i_nv_wr, // Store strobe
   input wire logic [15:0] i_nv_data, // Value to store
   output rsr_pkg::rsr_pins_t o_pins, // Contact levels
   output logic [15:0] o_nv_mem // Stored setpoint
);
   timeunit 1ns;
   timeprecision 1ns;
   rsr_pkg::rsr_pins_t pins = '0;
   logic [15:0] mem = 16'h0019; // Power-up content, arbitrary
   // Contacts move just after an edge; memory survives reset
   always @(posedge i_clk_sys) begin
      pins <= i_want;
      if (i_nv_wr) begin
         mem <= i_nv_data;
      end
   end
   assign o_pins = pins;
   assign o_nv_mem = mem;
endmodule

// >>> test/rsr_top_tb.sv
// Self-checking bench for the remote speed and ramp block
`include "rsr_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("FAIL %s exp %h got %h", nm, e, g); end end
module rsr_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned STORE = 2000;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, exp_r;
   logic [15:0] exp_n, main_f, nv_data, nv_mem, out_f, set_f;
   logic prdy, perr, nv_wr;
   rsr_pkg::rsr_pins_t want = '0;
   rsr_pkg::rsr_pins_t p;
   logic [31:0] rd_q[$];
   logic [15:0] nv_q[$];
   int fails = 0;
   int samples_checked = 0;
   rsr_far_model u_far (.i_clk_sys(clk), .i_want(want), .i_nv_wr(nv_wr),
      .i_nv_data(nv_data), .o_pins(p), .o_nv_mem(nv_mem));
   rsr_top #(.STORE_CYC(STORE)) u_dut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd),
      .o_pready(prdy), .o_pslverr(perr), .i_remote_up_input(p.remote_up_input),
      .i_remote_down_input(p.remote_down_input), .i_remote_clear_input(p.remote_clear_input),
      .i_second_function_select(p.second_function_select), .i_jog_active(p.jog_active),
      .i_forward_run_cmd(p.forward_run_cmd), .i_reverse_run_cmd(p.reverse_run_cmd),
      .i_pid_active(p.pid_active), .i_nv_data(nv_mem), .o_nv_wr(nv_wr),
      .o_nv_data(nv_data), .o_out_freq(out_f), .o_set_freq(set_f));
   // Clock of 100 ns
   initial begin
      forever #50 clk = ~clk;
   end
   // ------
   // Tasks
   // ------
   task automatic test_done();
      fails += rd_q.size() + nv_q.size();
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer, then one idle cycle so the next setup never collides
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         test_done();
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic power_cycle();
      arst_n <= 1'b0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Oldest note against each finished read and each store strobe
   always @(posedge clk) begin
      if (psel && pen && !pwr && prdy === 1'b1) begin
         exp_r = rd_q.pop_front();
         `CHK("prdata", exp_r, prd)
      end
      if (nv_wr === 1'b1) begin
         exp_n = nv_q.size() ? nv_q.pop_front() : 16'hxxxx;
         `CHK("nv_data", exp_n, nv_data)
      end
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      test_done();
   end
   // ------
   // Sequence
   // ------
   initial begin
      void'($urandom(74242));
      power_cycle();
      rd(`RSR_OFF_MAXF, `RSR_RST_MAXF);
      rd(`RSR_OFF_REFF, `RSR_RST_REFF);
      rd(`RSR_OFF_ACC1, `RSR_RST_TIME);
      rd(`RSR_OFF_DEC2, `RSR_RST_DEC2);
      rd(`RSR_OFF_SWF, `RSR_RST_SWF);
      rd(`RSR_OFF_REMF, 16'h0019);
      rd(8'h40, 32'h0);
      // Fast ramps: 25 cycles a step; mode 2 spares storage on frequent changes
      apb(1'b1, `RSR_OFF_MAXF, 32'd40);
      apb(1'b1, `RSR_OFF_REFF, `RSR_FREQ_MAX);
      for (int a = 0; a < 3; a++) apb(1'b1, 8'h0c + 8'(4 * a), 32'h1);
      main_f = 16'($urandom_range(100, 1));
      apb(1'b1, `RSR_OFF_MAIN, {16'h0, main_f});
      apb(1'b1, `RSR_OFF_CTRL, 32'h6);
      want.remote_up_input <= 1'b1;
      repeat (1500) @(posedge clk);
      rd(`RSR_OFF_REMF, 16'd40);
      rd(`RSR_OFF_NVF, 16'h0019);
      apb(1'b1, `RSR_OFF_SWF, 32'h0);
      want.remote_up_input <= 1'b0;
      want.forward_run_cmd <= 1'b1;
      repeat (4000) @(posedge clk);
      `CHK("out_freq", main_f + 16'd40, out_f)
      rd(`RSR_OFF_OUTF, main_f + 16'd40);
      rd(`RSR_OFF_STAT, 32'h7);
      want.forward_run_cmd <= 1'b0;
      repeat (4000) @(posedge clk);
      rd(`RSR_OFF_OUTF, 32'h0);
      // Lowered maximum caps the set value at once; remote then steps down to it
      apb(1'b1, `RSR_OFF_MAXF, 32'd30);
      @(posedge clk);
      `CHK("set_freq", main_f + 16'd30, set_f)
      repeat (300) @(posedge clk);
      apb(1'b1, `RSR_OFF_MAXF, 32'd40);
      // Clear is ignored in jog, acts after it; mode 0 ignores raise
      apb(1'b1, `RSR_OFF_CTRL, 32'h7);
      want.jog_active <= 1'b1;
      want.remote_clear_input <= 1'b1;
      repeat (20) @(posedge clk);
      rd(`RSR_OFF_REMF, 16'd30);
      want.jog_active <= 1'b0;
      repeat (8) @(posedge clk);
      rd(`RSR_OFF_REMF, 32'h0);
      want.remote_clear_input <= 1'b0;
      apb(1'b1, `RSR_OFF_CTRL, 32'h4);
      want.remote_up_input <= 1'b1;
      repeat (200) @(posedge clk);
      rd(`RSR_OFF_REMF, 32'h0);
      // Storage after the quiet period, restore across power loss
      apb(1'b1, `RSR_OFF_CTRL, 32'h5);
      repeat (1500) @(posedge clk);
      nv_q.push_back(16'd40);
      want.remote_up_input <= 1'b0;
      repeat (STORE + 500) @(posedge clk);
      want.remote_clear_input <= 1'b1;
      repeat (20) @(posedge clk);
      want.remote_clear_input <= 1'b0;
      power_cycle();
      rd(`RSR_OFF_REMF, 16'd40);
      apb(1'b1, `RSR_OFF_CTRL, 32'h1);
      want.remote_down_input <= 1'b1;
      repeat (4) @(posedge clk);
      want.remote_down_input <= 1'b0;
      want.remote_clear_input <= 1'b1;
      nv_q.push_back(16'h0);
      repeat (STORE + 500) @(posedge clk);
      want.remote_clear_input <= 1'b0;
      power_cycle();
      rd(`RSR_OFF_REMF, 32'h0);
      test_done();
   end
endmodule
bind rsr_top rsr_top_checker u_chk (.i_clk_sys, .i_arst_n, .i_psel, .i_penable, .i_paddr,
   .o_pslverr, .i_forward_run_cmd, .i_reverse_run_cmd, .i_jog_active, .o_nv_wr,
   .o_nv_data, .o_out_freq, .o_set_freq);
